// ==== inc/din_pkg.sv ====
package din_pkg;
   // channel count
   localparam int NUM_CH = 32;
   // i/o window: 32 bytes, aligned on 32 bytes
   localparam int WIN_BYTES = 32;
   localparam int WIN_ABITS = 5;
   localparam int ADDR_W = 16;
   // filter setting width and reset values
   localparam int FILT_W = 4;
   localparam logic [FILT_W-1:0] FILT_RST = 4'h0;
   // one filter tick is this many clocks; 1 us at 50 MHz
   localparam int CLK_MHZ = 50;
   localparam int TICK_NS = 1000;
   localparam int TICK_CYC = (TICK_NS * CLK_MHZ) / 1000;
   localparam logic [31:0] ZERO32 = 32'h0000_0000;

   typedef struct packed {
      logic [31:0] enable;
      logic [31:0] rising;
      logic [31:0] clear;
   } irq_cfg_t;
endpackage

// ==== hw/isolated_input_irq_filter.sv ====
`timescale 1ns/1ps
// How it works
// - pin high reads 0, pin low reads 1
// - thirty-two readable inputs, each interrupt capable
// - enabled flags merge into one request
// - per input rising or falling edge select
// - per input interrupt enable gates flag
// - software-set digital filter on every input
// - window decode is 32 bytes, 32-aligned
module isolated_input_irq_filter import din_pkg::*; #(
   parameter int CH = NUM_CH,
   parameter int TICK = TICK_CYC
) (
   // clock and reset
   input wire logic mclk,
   input wire logic resetn,
   // isolated input pins
   input wire logic [CH-1:0] pin_in,
   // window decode
   input wire logic [ADDR_W-1:0] io_addr,
   input wire logic [ADDR_W-1:0] io_base,
   output logic win_hit,
   // control
   input wire logic [FILT_W-1:0] filt_sel,
   input wire irq_cfg_t irq_cfg,
   // status
   output logic [CH-1:0] din_value,
   output logic [CH-1:0] irq_flag,
   output logic irq_req
);
   // counters sized from the parameters; the tick counter is kept
   // just wide enough for the configured tick length
   localparam int TICK_W = (TICK > 1) ? $clog2(TICK) : 1;
   localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK - 1);
   localparam logic [TICK_W-1:0] TICK_ZERO = '0;
   localparam logic [TICK_W-1:0] TICK_ONE = TICK_W'(1);
   localparam logic [FILT_W-1:0] FILT_ONE = FILT_W'(1);
   // pins idle high; a synchroniser reset low would fake an edge on
   // every channel at the first clock after reset
   localparam logic [CH-1:0] PIN_IDLE = '1;
   localparam logic VAL_IDLE = 1'b0;
   localparam logic FLAG_IDLE = 1'b0;

   // refuse settings the counters and the decode cannot serve
   if (CH < 1 || CH > NUM_CH) begin : g_bad_ch
      $error("channel count out of range");
   end
   if (TICK < 1) begin : g_bad_tick
      $error("tick must be at least one clock");
   end
   if (WIN_BYTES != (1 << WIN_ABITS)) begin : g_bad_win
      $error("window size and decode width disagree");
   end
   if (WIN_ABITS >= ADDR_W) begin : g_bad_addr
      $error("window decode wider than the address");
   end
   if ($bits(irq_cfg_t) != 3 * NUM_CH) begin : g_bad_cfg
      $error("interrupt settings do not cover every channel");
   end

   // synchroniser
   logic [CH-1:0] sync1_q;
   logic [CH-1:0] sync1_d;
   logic [CH-1:0] sync2_q;
   logic [CH-1:0] sync2_d;
   // filter timebase
   logic [TICK_W-1:0] tick_q;
   logic [TICK_W-1:0] tick_d;
   logic tick_p;
   // per-channel results gathered for the ports
   wire logic [CH-1:0] val_all;
   wire logic [CH-1:0] flag_all;
   // request merge and window decode
   logic req_d;
   logic [ADDR_W-WIN_ABITS-1:0] addr_blk;
   logic [ADDR_W-WIN_ABITS-1:0] base_blk;

   // two-flop synchroniser; only the second stage feeds the filters
   always_comb begin
      sync1_d = pin_in;
      sync2_d = sync1_q;
   end

   // synchroniser state
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         sync1_q <= PIN_IDLE;
         sync2_q <= PIN_IDLE;
      end else begin
         sync1_q <= sync1_d;
         sync2_q <= sync2_d;
      end
   end

   // shared filter timebase: one pulse every TICK clocks; one counter
   // for all channels trades a partial first tick for much less logic
   always_comb begin
      tick_p = (tick_q == TICK_LAST);
      if (tick_p) begin
         tick_d = TICK_ZERO;
      end else begin
         tick_d = tick_q + TICK_ONE;
      end
   end

   // timebase state
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         tick_q <= TICK_ZERO;
      end else begin
         tick_q <= tick_d;
      end
   end

   // per channel: filter, edge select and sticky flag
   for (genvar g = 0; g < CH; g++) begin : g_ch
      // filter state
      logic raw;
      logic differs;
      logic filt_off;
      logic count_done;
      logic [FILT_W-1:0] cnt_q;
      logic [FILT_W-1:0] cnt_d;
      logic [FILT_W-1:0] cnt_inc;
      logic val_q;
      logic val_d;
      // edge and flag state
      logic rise_hit;
      logic fall_hit;
      logic edge_hit;
      logic flag_set;
      logic flag_keep;
      logic flag_q;
      logic flag_d;

      // the value flips only once the raw level has stood opposite
      // across filt_sel tick pulses; zero passes it straight through.
      // the first tick may come early, so a step can be one tick short
      always_comb begin
         raw = ~sync2_q[g];
         differs = (raw != val_q);
         filt_off = (filt_sel == FILT_RST);
         cnt_inc = cnt_q + FILT_ONE;
         count_done = (cnt_inc >= filt_sel);
         cnt_d = cnt_q;
         val_d = val_q;
         if (!differs) begin
            cnt_d = FILT_RST;
         end else if (filt_off) begin
            val_d = raw;
         end else if (tick_p) begin
            if (count_done) begin
               val_d = raw;
               cnt_d = FILT_RST;
            end else begin
               cnt_d = cnt_inc;
            end
         end
      end

      // idle pins read 0, so the filtered value resets to 0
      always_ff @(posedge mclk or negedge resetn) begin
         if (!resetn) begin
            cnt_q <= FILT_RST;
            val_q <= VAL_IDLE;
         end else begin
            cnt_q <= cnt_d;
            val_q <= val_d;
         end
      end

      // edge select and sticky flag; a set beats a clear in one cycle.
      // clear is a level: held high it keeps clearing every cycle
      always_comb begin
         rise_hit = val_d & ~val_q;
         fall_hit = ~val_d & val_q;
         if (irq_cfg.rising[g]) begin
            edge_hit = rise_hit;
         end else begin
            edge_hit = fall_hit;
         end
         flag_set = edge_hit & irq_cfg.enable[g];
         flag_keep = flag_q & ~irq_cfg.clear[g];
         flag_d = flag_set | flag_keep;
      end

      // flag state
      always_ff @(posedge mclk or negedge resetn) begin
         if (!resetn) begin
            flag_q <= FLAG_IDLE;
         end else begin
            flag_q <= flag_d;
         end
      end

      assign val_all[g] = val_q;
      assign flag_all[g] = flag_q;
   end

   // request merge
   always_comb begin
      // a flag kept from an enabled spell is masked once disabled
      req_d = |(flag_all & irq_cfg.enable[CH-1:0]);
   end

   // window decode: only the bits above the 32-byte block are compared,
   // so any base on a block boundary works and its low bits are ignored
   always_comb begin
      addr_blk = io_addr[ADDR_W-1:WIN_ABITS];
      base_blk = io_base[ADDR_W-1:WIN_ABITS];
   end

   // outputs: values and flags straight from flip-flops
   assign din_value = val_all;
   assign irq_flag = flag_all;
   assign irq_req = req_d;
   assign win_hit = (addr_blk == base_blk);
endmodule // isolated_input_irq_filter

// ==== dv/din_src.sv ====
`timescale 1ns/1ps
module din_src (
   input wire logic [31:0] on_m,
   output logic [31:0] pin
);
   assign pin = ~on_m;
endmodule // din_src

// ==== dv/din_chk.sv ====
`timescale 1ns/1ps
module din_chk import din_pkg::*; (
   input wire logic mclk, resetn, win_hit, irq_req,
   input wire logic [31:0] pin_in, din_value, irq_flag,
   input wire logic [15:0] io_addr, io_base,
   input wire logic [3:0] filt_sel,
   input wire irq_cfg_t irq_cfg
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!resetn);
   property p_req; irq_req == |(irq_flag & irq_cfg.enable); endproperty
   a_req: assert property (p_req) else $error("req");
   property p_off;
      (irq_flag & ~$past(irq_flag | irq_cfg.enable)) == 0; endproperty
   a_off: assert property (p_off) else $error("off");
   property p_edg; (irq_flag & ~$past(irq_flag) & ~((din_value ^
      $past(din_value)) & ~(din_value ^ $past(irq_cfg.rising)))) == 0;
   endproperty
   a_edg: assert property (p_edg) else $error("edge");
   property p_stk;
      (~irq_flag & $past(irq_flag) & ~$past(irq_cfg.clear)) == 0; endproperty
   a_stk: assert property (p_stk) else $error("stick");
   property p_clr; (irq_flag & $past(irq_cfg.clear)
      & ~(din_value ^ $past(din_value))) == 0; endproperty
   a_clr: assert property (p_clr) else $error("clear");
   property p_inv; filt_sel == 4'h0 |-> din_value == ~$past(pin_in, 3);
   endproperty
   a_inv: assert property (p_inv) else $error("inv");
   property p_flt; filt_sel >= 4'h2 && din_value != $past(din_value)
      |-> $past(pin_in, 3) == $past(pin_in, 4); endproperty
   a_flt: assert property (p_flt) else $error("filt");
   property p_win; win_hit == (io_addr[15:5] == io_base[15:5]); endproperty
   a_win: assert property (p_win) else $error("win");
   sequence s_set0; !irq_flag[0] ##1 irq_flag[0]; endsequence
   sequence s_keep0; !irq_cfg.clear[0]; endsequence
   property p_hold; s_set0 ##0 s_keep0 |=> irq_flag[0]; endproperty
   a_hold: assert property (p_hold) else $error("hold");
endmodule // din_chk
bind isolated_input_irq_filter din_chk chk_i (.mclk, .resetn, .win_hit,
   .irq_req, .pin_in, .din_value, .irq_flag, .io_addr, .io_base,
   .filt_sel, .irq_cfg);

// ==== dv/isolated_input_irq_filter_bench.sv ====
`timescale 1ns/1ps
module isolated_input_irq_filter_bench import din_pkg::*;;
   logic mclk = 0, resetn = 0, w, rq;
   logic [31:0] on_m = '0, pin, dv, fl;
   logic [15:0] a = 16'h0300, b = 16'h0300;
   logic [3:0] fs = 4'h0;
   irq_cfg_t c = '0;
   int failures = 0, checks_done = 0;
   din_src src (.on_m(on_m), .pin(pin));
   isolated_input_irq_filter #(.TICK(2)) dut (.mclk, .resetn, .pin_in(pin),
      .io_addr(a), .io_base(b), .win_hit(w), .filt_sel(fs),
      .irq_cfg(c), .din_value(dv), .irq_flag(fl), .irq_req(rq));
   task automatic chk(logic [31:0] s, e);
      checks_done++;
      if (s !== e) begin
         failures++;
         $display("Error %0t bad value", $time);
      end
   endtask
   task automatic cyc(int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask
   task automatic complete_run;
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   initial forever #10 mclk = ~mclk;
   initial begin
      #20000;
      failures++;
      complete_run;
   end
   initial begin
      cyc(3);
      resetn = 1;
      c.enable = 32'h8000_0001;
      c.rising = 32'h0000_0001;
      on_m = 32'h8000_0003;
      cyc(3);
      chk(dv, 32'h8000_0003);
      chk(fl, 32'h0000_0001);
      cyc(4);
      chk({31'h0, rq}, 32'h1);
      c.clear = 32'h0000_0001;
      cyc(1);
      c.clear = '0;
      chk({fl[30:0], rq}, 32'h0);
      on_m = '0;
      cyc(3);
      chk(fl, 32'h8000_0000);
      c.enable = '0;
      cyc(1);
      chk({31'h0, rq}, 32'h0);
      $display("test irq done");
      a = 16'h031F;
      cyc(1);
      chk({31'h0, w}, 32'h1);
      a = 16'h0320;
      cyc(1);
      chk({31'h0, w}, 32'h0);
      b = 16'h0320;
      cyc(1);
      chk({31'h0, w}, 32'h1);
      $display("test window done");
      fs = 4'h2;
      on_m = 32'h1;
      cyc(1);
      on_m = '0;
      cyc(12);
      chk(dv, 32'h0);
      on_m = 32'h1;
      cyc(12);
      chk(dv, 32'h1);
      $display("test filter done");
      complete_run;
   end
endmodule // isolated_input_irq_filter_bench
